// ---- hw/psw_defs.svh ----
// Register map, field positions, reset values and timing for the
// power-save, wake and boot-source block. Definitions only.
`ifndef PSW_DEFS_SVH
`define PSW_DEFS_SVH

`define PSW_ADDR_W          8
`define PSW_DATA_W          32

`define PSW_ADDR_CTRL       8'h00
`define PSW_ADDR_WAKE_CFG   8'h04
`define PSW_ADDR_STATUS     8'h08
`define PSW_ADDR_IRQ_STAT   8'h0c
`define PSW_ADDR_IRQ_MASK   8'h10

// Control register fields
`define PSW_CTRL_SLEEP      0
`define PSW_CTRL_LAMP_ON    1
`define PSW_CTRL_LAMP_OE    2
`define PSW_CTRL_W          3
`define PSW_CTRL_RESET      3'h4

// Wake configuration fields, enable and polarity per input
`define PSW_WCFG_EN_A       0
`define PSW_WCFG_POL_A      1
`define PSW_WCFG_EN_B       2
`define PSW_WCFG_POL_B      3
`define PSW_WCFG_W          4
`define PSW_WCFG_RESET      4'h0

// Status register fields
`define PSW_STAT_ACTIVE     0
`define PSW_STAT_HOST_BOOT  1

// Interrupt status and mask fields
`define PSW_IRQ_WAKE_A      0
`define PSW_IRQ_WAKE_B      1
`define PSW_IRQ_RTS         2
`define PSW_IRQ_SLEPT       3
`define PSW_IRQ_W           4
`define PSW_IRQ_RESET       4'h0

// Timing
`define PSW_CLK_PERIOD_NS   40
`define PSW_WAKE_MIN_NS     100000

`endif

// ---- hw/psw_pkg.sv ----
// Types shared by the power-save, wake and boot-source block.
// Assumes the constants header is compiled alongside.
package psw_pkg;

    typedef enum logic {
        PSW_ACTIVE,
        PSW_LOW
    } psw_state_type;

endpackage

// ---- hw/psw_wake_qual.sv ----
// One wake input qualifier: enable, polarity and minimum hold time.
// Assumes the input level is synchronous to clk.
`timescale 1ns/1ps
`include "psw_defs.svh"

module psw_wake_qual #(
    parameter int MIN_CYCLES = 2500,
    parameter int CNT_W      = 12
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic hold,
    input  wire logic enable,
    input  wire logic polarity,
    input  wire logic level,
    output logic      wake_event
);
    import psw_pkg::*;

    // Count saturates one past the firing value, so a held level fires once
    localparam logic [CNT_W-1:0] LAST = CNT_W'(MIN_CYCLES);

    logic [CNT_W-1:0] cnt_q;
    logic             evt_q;
    logic             match;

    generate
        if (MIN_CYCLES < 1 || MIN_CYCLES >= (1 << CNT_W)) begin : g_bad
            $error("psw_wake_qual: MIN_CYCLES does not fit CNT_W");
        end
    endgenerate

    assign match = enable && (level == polarity);

    // count continuous match, restart on mismatch
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q <= '0;
        end else if (hold || !match) begin
            cnt_q <= '0;
        end else if (cnt_q != LAST) begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    // one event per qualified hold, never repeated while held
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            evt_q <= 1'b0;
        end else begin
            evt_q <= !hold && match && (cnt_q == LAST - CNT_W'(1));
        end
    end

    assign wake_event = evt_q;

    AST_RESTART: assert property (@(posedge clk) disable iff (reset)
        !match |=> cnt_q == '0)
        else $error("qualifier count not restarted on mismatch");

    AST_POLARITY: assert property (@(posedge clk) disable iff (reset)
        wake_event |-> $past(level) == $past(polarity) && $past(enable))
        else $error("wake event against configured polarity");

endmodule

// ---- hw/psw_ctrl.sv ----
// Power-save status, wake qualification, boot-source capture, status
// lamp and register/interrupt logic of the module.
// Assumes all inputs synchronous to clk (25 MHz) and a simple strobe bus.
//
// Summary of operation
// - Indicator high while the module is active.
// - Indicator low while the module is in low power mode.
// - Wake inputs are level triggered with software-selected polarity.
// - Wake level must be held at least 100 us to be recognised.
// - Both wake inputs disabled after reset until software enables them.
// - Boot select high means flash firmware, low means host firmware.
// - Module held in reset while reset input low, released when high.
// - Lamp pin is an output, lamp inactive after reset.
// - Host boot mode enables third serial port recovery with flow control.
`timescale 1ns/1ps
`include "psw_defs.svh"

module psw_ctrl #(
    parameter int WAKE_MIN_CYCLES =
        (`PSW_WAKE_MIN_NS + `PSW_CLK_PERIOD_NS - 1) / `PSW_CLK_PERIOD_NS,
    parameter int WAKE_CNT_W      = 12
) (
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire logic                    module_reset_low,
    input  wire logic                    boot_source_select,
    input  wire logic                    primary_port_request_to_send,
    input  wire logic                    wake_input_a,
    input  wire logic                    wake_input_b,
    input  wire logic [`PSW_ADDR_W-1:0]  reg_addr,
    input  wire logic [`PSW_DATA_W-1:0]  reg_wdata,
    input  wire logic                    reg_write,
    input  wire logic                    reg_read,
    output logic      [`PSW_DATA_W-1:0]  reg_rdata,
    output logic                         power_save_indicator,
    output psw_pkg::psw_state_type       power_state,
    output logic                         flash_firmware_boot,
    output logic                         host_firmware_boot,
    output logic                         recovery_port_enable,
    output logic                         status_lamp_output,
    output logic                         status_lamp_oe,
    output logic                         irq
);
    import psw_pkg::*;

    localparam int NWAKE = 2;

    generate
        if (WAKE_MIN_CYCLES < 2) begin : g_bad_min
            $error("psw_ctrl: WAKE_MIN_CYCLES must be at least 2");
        end
    endgenerate

    psw_state_type              state_q;
    psw_state_type              state_d;
    logic                       ind_q;
    logic [`PSW_CTRL_W-1:0]     ctrl_q;
    logic [`PSW_WCFG_W-1:0]     wcfg_q;
    logic [`PSW_IRQ_W-1:0]      istat_q;
    logic [`PSW_IRQ_W-1:0]      istat_set;
    logic [`PSW_IRQ_W-1:0]      imask_q;
    logic [`PSW_DATA_W-1:0]     rdata_q;
    logic                       boot_done_q;
    logic                       host_boot_q;
    logic                       hold;
    logic                       sleep_go;
    logic                       rts_wake;
    logic                       wake_any;
    logic [NWAKE-1:0]           wake_lvl;
    logic [NWAKE-1:0]           wake_en;
    logic [NWAKE-1:0]           wake_pol;
    logic [NWAKE-1:0]           wake_evt;

    // low reset input holds every register but the read data at its reset value
    assign hold = !module_reset_low;

    assign wake_lvl = {wake_input_b, wake_input_a};
    assign wake_en  = {wcfg_q[`PSW_WCFG_EN_B], wcfg_q[`PSW_WCFG_EN_A]};
    assign wake_pol = {wcfg_q[`PSW_WCFG_POL_B], wcfg_q[`PSW_WCFG_POL_A]};

    generate
        for (genvar i = 0; i < NWAKE; i++) begin : g_wake
            psw_wake_qual #(
                .MIN_CYCLES (WAKE_MIN_CYCLES),
                .CNT_W      (WAKE_CNT_W)
            ) u_qual (
                .clk        (clk),
                .reset      (reset),
                .hold       (hold),
                .enable     (wake_en[i]),
                .polarity   (wake_pol[i]),
                .level      (wake_lvl[i]),
                .wake_event (wake_evt[i])
            );
        end
    endgenerate

    // request-to-send high is a wake request while asleep
    assign rts_wake = (state_q == PSW_LOW) && primary_port_request_to_send;
    assign wake_any = rts_wake || (|wake_evt);

    assign sleep_go = reg_write && (reg_addr == `PSW_ADDR_CTRL)
                      && reg_wdata[`PSW_CTRL_SLEEP];

    // Power state; a wake in the same cycle beats a sleep request
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            PSW_ACTIVE: begin
                if (sleep_go && !wake_any) begin
                    state_d = PSW_LOW;
                end
            end
            PSW_LOW: begin
                if (wake_any) begin
                    state_d = PSW_ACTIVE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= PSW_ACTIVE;
        end else if (hold) begin
            state_q <= PSW_ACTIVE;
        end else begin
            state_q <= state_d;
        end
    end

    // low power state drives indicator low
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ind_q <= 1'b1;
        end else if (hold) begin
            ind_q <= 1'b1;
        end else begin
            ind_q <= (state_d == PSW_ACTIVE);
        end
    end

    assign power_save_indicator = ind_q;
    assign power_state          = state_q;

    // lamp pin output and inactive from reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_q <= `PSW_CTRL_RESET;
        end else if (hold) begin
            ctrl_q <= `PSW_CTRL_RESET;
        end else if (reg_write && reg_addr == `PSW_ADDR_CTRL) begin
            // Sleep bit is a command, never stored
            ctrl_q <= {reg_wdata[`PSW_CTRL_LAMP_OE], reg_wdata[`PSW_CTRL_LAMP_ON], 1'b0};
        end
    end

    assign status_lamp_output = ctrl_q[`PSW_CTRL_LAMP_ON];
    assign status_lamp_oe     = ctrl_q[`PSW_CTRL_LAMP_OE];

    // wake inputs A and B disabled until software enables them
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wcfg_q <= `PSW_WCFG_RESET;
        end else if (hold) begin
            wcfg_q <= `PSW_WCFG_RESET;
        end else if (reg_write && reg_addr == `PSW_ADDR_WAKE_CFG) begin
            wcfg_q <= reg_wdata[`PSW_WCFG_W-1:0];
        end
    end

    // capture boot select once after reset release
    // low select chooses host firmware, high chooses flash
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            boot_done_q <= 1'b0;
            host_boot_q <= 1'b0;
        end else if (hold) begin
            boot_done_q <= 1'b0;
            host_boot_q <= 1'b0;
        end else if (!boot_done_q) begin
            boot_done_q <= 1'b1;
            host_boot_q <= !boot_source_select;
        end
    end

    assign host_firmware_boot  = host_boot_q;
    assign flash_firmware_boot = boot_done_q && !host_boot_q;
    // host boot opens third port recovery path
    assign recovery_port_enable = host_boot_q;

    // Sticky events; a set in the clearing cycle survives
    always_comb begin
        istat_set = '0;
        istat_set[`PSW_IRQ_WAKE_A] = wake_evt[0];
        istat_set[`PSW_IRQ_WAKE_B] = wake_evt[1];
        istat_set[`PSW_IRQ_RTS]    = rts_wake;
        istat_set[`PSW_IRQ_SLEPT]  = (state_q == PSW_ACTIVE) && (state_d == PSW_LOW);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            istat_q <= `PSW_IRQ_RESET;
        end else if (hold) begin
            istat_q <= `PSW_IRQ_RESET;
        end else if (reg_write && reg_addr == `PSW_ADDR_IRQ_STAT) begin
            istat_q <= (istat_q & ~reg_wdata[`PSW_IRQ_W-1:0]) | istat_set;
        end else begin
            istat_q <= istat_q | istat_set;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            imask_q <= `PSW_IRQ_RESET;
        end else if (hold) begin
            imask_q <= `PSW_IRQ_RESET;
        end else if (reg_write && reg_addr == `PSW_ADDR_IRQ_MASK) begin
            imask_q <= reg_wdata[`PSW_IRQ_W-1:0];
        end
    end

    assign irq = |(istat_q & imask_q);

    // Read data stands for one cycle only; unmapped reads return zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_q <= '0;
        end else if (!reg_read) begin
            rdata_q <= '0;
        end else begin
            unique case (reg_addr)
                `PSW_ADDR_CTRL:     rdata_q <= {{(`PSW_DATA_W-`PSW_CTRL_W){1'b0}}, ctrl_q};
                `PSW_ADDR_WAKE_CFG: rdata_q <= {{(`PSW_DATA_W-`PSW_WCFG_W){1'b0}}, wcfg_q};
                `PSW_ADDR_STATUS:   rdata_q <= {{(`PSW_DATA_W-2){1'b0}}, host_boot_q, ind_q};
                `PSW_ADDR_IRQ_STAT: rdata_q <= {{(`PSW_DATA_W-`PSW_IRQ_W){1'b0}}, istat_q};
                `PSW_ADDR_IRQ_MASK: rdata_q <= {{(`PSW_DATA_W-`PSW_IRQ_W){1'b0}}, imask_q};
                default:            rdata_q <= '0;
            endcase
        end
    end

    assign reg_rdata = rdata_q;

    // Assertions

    AST_WAKE_RAISES: assert property (@(posedge clk) disable iff (reset)
        module_reset_low && state_q == PSW_LOW && wake_any
        |=> power_save_indicator ##1 (power_save_indicator || $past(sleep_go)))
        else $error("indicator not high after wake");

    AST_SLEEP_DROPS: assert property (@(posedge clk) disable iff (reset)
        module_reset_low && state_q == PSW_ACTIVE && sleep_go && !wake_any
        |=> !power_save_indicator && istat_q[`PSW_IRQ_SLEPT])
        else $error("indicator not low after sleep request");

    AST_LOW_HOLDS: assert property (@(posedge clk) disable iff (reset)
        module_reset_low && state_q == PSW_LOW && !wake_any
        |=> !power_save_indicator)
        else $error("indicator left low power without wake");

    AST_DISABLED_QUIET: assert property (@(posedge clk) disable iff (reset)
        !wcfg_q[`PSW_WCFG_EN_A] [*2] |-> !wake_evt[0])
        else $error("wake event from disabled input");

    AST_SHORT_IGNORED: assert property (@(posedge clk) disable iff (reset)
        $rose(wake_evt[1]) |-> $past(wake_en[1] && wake_lvl[1] == wake_pol[1], 2))
        else $error("wake accepted without held level");

    AST_BOOT_SEL: assert property (@(posedge clk) disable iff (reset)
        $rose(boot_done_q) |-> host_firmware_boot == !$past(boot_source_select))
        else $error("boot source not taken from select pin");

    AST_BOOT_FIXED: assert property (@(posedge clk) disable iff (reset)
        boot_done_q && module_reset_low |=> $stable(host_firmware_boot))
        else $error("boot source changed after capture");

    AST_HOLD_RESET: assert property (@(posedge clk) disable iff (reset)
        !module_reset_low |=> power_save_indicator && wcfg_q == '0 && !irq)
        else $error("state not cleared while reset input low");

    AST_LAMP_RESET: assert property (@(posedge clk) disable iff (reset)
        !module_reset_low |=> status_lamp_oe && !status_lamp_output)
        else $error("lamp not idle output after reset");

    AST_RECOVERY: assert property (@(posedge clk) disable iff (reset)
        $rose(boot_done_q) && !$past(boot_source_select) |-> recovery_port_enable)
        else $error("recovery port not enabled in host boot");

    AST_RTS_WAKE: assert property (@(posedge clk) disable iff (reset)
        module_reset_low && !power_save_indicator && primary_port_request_to_send
        |=> power_save_indicator)
        else $error("request-to-send did not wake module");

    AST_WAKE_WINS: assert property (@(posedge clk) disable iff (reset)
        module_reset_low && sleep_go && wake_any
        |=> power_save_indicator && power_state == PSW_ACTIVE)
        else $error("sleep request beat a wake in the same cycle");

    AST_ACTIVE_HOLDS: assert property (@(posedge clk) disable iff (reset)
        module_reset_low && power_state == PSW_ACTIVE && !sleep_go
        |=> power_state == PSW_ACTIVE && power_save_indicator)
        else $error("module left active state without sleep request");

    AST_STATUS_READ: assert property (@(posedge clk) disable iff (reset)
        reg_read && reg_addr == `PSW_ADDR_STATUS
        |=> reg_rdata[`PSW_STAT_ACTIVE] == $past(power_save_indicator)
            && reg_rdata[`PSW_STAT_HOST_BOOT] == $past(host_firmware_boot))
        else $error("status read does not show indicator and boot source");

    AST_CFG_ONLY_SW: assert property (@(posedge clk) disable iff (reset)
        wcfg_q == '0 && !(reg_write && reg_addr == `PSW_ADDR_WAKE_CFG)
        |=> wcfg_q == '0)
        else $error("wake source enabled without a configuration write");

    AST_SLEPT_STICKY: assert property (@(posedge clk) disable iff (reset)
        module_reset_low && istat_q[`PSW_IRQ_SLEPT]
        && !(reg_write && reg_addr == `PSW_ADDR_IRQ_STAT && reg_wdata[`PSW_IRQ_SLEPT])
        |=> istat_q[`PSW_IRQ_SLEPT])
        else $error("low power event lost without a clear");

    COV_SLEEP_WAKE: cover property (@(posedge clk) disable iff (reset)
        !power_save_indicator ##1 wake_evt[0] ##1 power_save_indicator);
    COV_HOST_BOOT: cover property (@(posedge clk) disable iff (reset)
        $rose(host_firmware_boot));
    COV_IRQ: cover property (@(posedge clk) disable iff (reset) $rose(irq));
    COV_WAKE_B: cover property (@(posedge clk) disable iff (reset) $rose(wake_evt[1]));
    COV_RTS_WAKE: cover property (@(posedge clk) disable iff (reset)
        rts_wake ##1 power_save_indicator);

endmodule

// ---- tb/psw_host_model.sv ----
// Host-side model: wake lines, request-to-send and boot-select strap.
// Assumes the bench calls its tasks; it drives only after rising clk edges.
`timescale 1ns/1ps

module psw_host_model (
    input  wire logic clk,
    input  wire logic power_save_indicator,
    output logic      rts,
    output logic      wake_a,
    output logic      wake_b,
    output logic      boot_sel
);
    initial begin
        rts      = 1'b0;
        wake_a   = 1'b0;
        wake_b   = 1'b1;
        boot_sel = 1'b1;
    end

    task automatic hold_wake(input logic b, input logic lvl, input int n);
        @(posedge clk);
        if (b) begin
            wake_b <= lvl;
        end else begin
            wake_a <= lvl;
        end
        repeat (n) @(posedge clk);
    endtask

    task automatic pulse_rts();
        @(posedge clk);
        rts <= 1'b1;
        repeat (2) @(posedge clk);
        rts <= 1'b0;
    endtask

    task automatic wake_for_traffic();
        if (power_save_indicator !== 1'b1) begin
            pulse_rts();
        end
    endtask

    task automatic set_boot(input logic v);
        @(posedge clk);
        boot_sel <= v;
    endtask
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the power-save, wake and boot-source block.
// Assumes the host model file and the design's constants header.
`timescale 1ns/1ps
`include "psw_defs.svh"

module tb_top;
    import psw_pkg::*;
    // Short qualify count keeps the run brief
    localparam int WMIN = 4;
    logic          clk;
    logic          reset;
    logic          module_reset_low;
    logic          rts;
    logic          wake_a;
    logic          wake_b;
    logic          boot_sel;
    logic [7:0]    reg_addr;
    logic [31:0]   reg_wdata;
    logic          reg_write;
    logic          reg_read;
    logic [31:0]   reg_rdata;
    logic          ind;
    psw_state_type power_state;
    logic          flash_boot;
    logic          host_boot;
    logic          recov;
    logic          lamp;
    logic          lamp_oe;
    logic          irq;
    int            n_fail = 0;
    int            n_compared = 0;
    int            cycles = 0;

    psw_ctrl #(.WAKE_MIN_CYCLES(WMIN), .WAKE_CNT_W(12)) i_psw_ctrl (
        .clk(clk), .reset(reset), .module_reset_low(module_reset_low),
        .boot_source_select(boot_sel), .primary_port_request_to_send(rts),
        .wake_input_a(wake_a), .wake_input_b(wake_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .power_save_indicator(ind), .power_state(power_state),
        .flash_firmware_boot(flash_boot), .host_firmware_boot(host_boot),
        .recovery_port_enable(recov), .status_lamp_output(lamp),
        .status_lamp_oe(lamp_oe), .irq(irq));

    psw_host_model i_psw_host_model (
        .clk(clk), .power_save_indicator(ind), .rts(rts), .wake_a(wake_a),
        .wake_b(wake_b), .boot_sel(boot_sel));

    always #20 clk = ~clk;

    task automatic finish_test();
        $display("compared=%0d failed=%0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            $display("[FAIL] t=%0t timeout got=%h exp=%h", $time, cycles, 0);
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(negedge clk);
        chk(reg_rdata, exp);
    endtask

    task automatic t_reset_values();
        @(negedge clk);
        chk(ind, 1'b1);
        chk(power_state, PSW_ACTIVE);
        chk({lamp_oe, lamp}, 2'b10);
        chk({host_boot, flash_boot, recov}, 3'b010);
        rd_chk(`PSW_ADDR_CTRL, 32'h4);
        rd_chk(`PSW_ADDR_WAKE_CFG, 32'h0);
        rd_chk(`PSW_ADDR_IRQ_MASK, 32'h0);
        rd_chk(8'h40, 32'h0);
    endtask

    task automatic t_sleep_rts();
        wr(`PSW_ADDR_IRQ_MASK, 32'h8);
        i_psw_host_model.pulse_rts();
        rd_chk(`PSW_ADDR_IRQ_STAT, 32'h0);
        wr(`PSW_ADDR_CTRL, 32'h1);
        @(negedge clk);
        chk(ind, 1'b0);
        chk(power_state, PSW_LOW);
        chk(irq, 1'b1);
        rd_chk(`PSW_ADDR_STATUS, 32'h0);
        wr(`PSW_ADDR_IRQ_STAT, 32'h8);
        @(negedge clk);
        chk(irq, 1'b0);
        i_psw_host_model.wake_for_traffic();
        @(negedge clk);
        chk(ind, 1'b1);
        chk(irq, 1'b0);
        rd_chk(`PSW_ADDR_IRQ_STAT, 32'h4);
        wr(`PSW_ADDR_IRQ_STAT, 32'h4);
    endtask

    task automatic t_wake();
        wr(`PSW_ADDR_CTRL, 32'h1);
        i_psw_host_model.hold_wake(1'b0, 1'b1, 20);
        i_psw_host_model.hold_wake(1'b0, 1'b0, 20);
        @(negedge clk);
        chk(ind, 1'b0);
        wr(`PSW_ADDR_WAKE_CFG, 32'h3);
        // Too short a hold must restart the count
        i_psw_host_model.hold_wake(1'b0, 1'b1, WMIN - 2);
        i_psw_host_model.hold_wake(1'b0, 1'b0, 10);
        @(negedge clk);
        chk(ind, 1'b0);
        i_psw_host_model.hold_wake(1'b0, 1'b1, WMIN + 3);
        @(negedge clk);
        chk(ind, 1'b1);
        rd_chk(`PSW_ADDR_IRQ_STAT, 32'h9);
        i_psw_host_model.hold_wake(1'b0, 1'b0, 1);
        wr(`PSW_ADDR_IRQ_STAT, 32'hf);
        wr(`PSW_ADDR_CTRL, 32'h1);
        wr(`PSW_ADDR_WAKE_CFG, 32'h4);
        i_psw_host_model.hold_wake(1'b1, 1'b0, WMIN + 3);
        @(negedge clk);
        chk(ind, 1'b1);
        rd_chk(`PSW_ADDR_IRQ_STAT, 32'ha);
        i_psw_host_model.hold_wake(1'b1, 1'b1, 1);
    endtask

    task automatic t_module_reset();
        wr(`PSW_ADDR_CTRL, 32'h6);
        @(negedge clk);
        chk({lamp_oe, lamp}, 2'b11);
        i_psw_host_model.set_boot(1'b0);
        @(posedge clk);
        module_reset_low <= 1'b0;
        repeat (3) @(posedge clk);
        wr(`PSW_ADDR_CTRL, 32'h1);
        @(negedge clk);
        chk(ind, 1'b1);
        chk({lamp_oe, lamp}, 2'b10);
        @(posedge clk);
        module_reset_low <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({host_boot, flash_boot, recov}, 3'b101);
        i_psw_host_model.set_boot(1'b1);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk({host_boot, flash_boot, recov}, 3'b101);
        rd_chk(`PSW_ADDR_STATUS, 32'h3);
    endtask

    initial begin
        clk              = 1'b0;
        reset            = 1'b1;
        module_reset_low = 1'b1;
        reg_addr         = 8'h00;
        reg_wdata        = 32'h0;
        reg_write        = 1'b0;
        reg_read         = 1'b0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset_values();
        t_sleep_rts();
        t_wake();
        t_module_reset();
        finish_test();
    end
endmodule
